// *** rtl/vsd_defs.svh ***
// Constants for the video sync detect and clock setup controller
`ifndef VSD_DEFS_SVH
`define VSD_DEFS_SVH

// Device register addresses
`define VSD_DEV_SYNC_ACT      8'h01
`define VSD_DEV_SYNC_POL      8'h02
`define VSD_DEV_HS_SLICER     8'h03
`define VSD_DEV_GREEN_SLICER  8'h04
`define VSD_DEV_INPUT_CFG     8'h05
`define VSD_DEV_RED_OFS       8'h09
`define VSD_DEV_GREEN_OFS     8'h0a
`define VSD_DEV_BLUE_OFS      8'h0b
`define VSD_DEV_OFS_LSB_RANGE 8'h0c
`define VSD_DEV_LINE_HI       8'h0e
`define VSD_DEV_LINE_LO       8'h0f
`define VSD_DEV_PHASE         8'h10
`define VSD_DEV_SERVO_CTL     8'h17

// Device field values and positions
`define VSD_GREEN_SLICER_DEF  8'h16
`define VSD_GREEN_LPF_MASK    8'h10
`define VSD_HS_THR_RISE       3'h1
`define VSD_HS_THR_FALL       3'h6
`define VSD_PHASE_MASK        8'h3f
`define VSD_ST_HS             0
`define VSD_ST_VS             1
`define VSD_ST_GREEN          2
`define VSD_ST_TRI            3
`define VSD_ST_COMPOSITE_SYNC          4
`define VSD_SEL_SEPARATE      2'h0
`define VSD_SEL_COMPOSITE_SYNC_HS      2'h1
`define VSD_SEL_COMPOSITE_SYNC_GREEN   2'h2

// Configuration sequence
`define VSD_CFG_LAST          4'h9
`define VSD_TRI_POLLS         3'h4

// Controller register map
`define VSD_REG_CTRL          4'h0
`define VSD_REG_LINE_HI       4'h1
`define VSD_REG_LINE_LO       4'h2
`define VSD_REG_PHASE         4'h3
`define VSD_REG_RED_OFS       4'h4
`define VSD_REG_GREEN_OFS     4'h5
`define VSD_REG_BLUE_OFS      4'h6
`define VSD_REG_OFS_LSB       4'h7
`define VSD_REG_RESULT        4'h8
`define VSD_REG_ACT           4'h9
`define VSD_REG_POL           4'ha

// Control register bits
`define VSD_CTRL_APPLY        0
`define VSD_CTRL_DETECT       1
`define VSD_CTRL_FALL         2
`define VSD_CTRL_SERVO_OFF    3
`define VSD_CTRL_RANGE        4

`endif

// *** rtl/vsd_pkg.sv ***
// Types shared by the sync detect controller
package vsd_pkg;
    typedef enum logic [5:0]
    {
        VSD_IDLE = 6'h01,
        VSD_CFG  = 6'h02,
        VSD_RD   = 6'h04,
        VSD_GAP  = 6'h08,
        VSD_CAP  = 6'h10,
        VSD_SEL  = 6'h20
    } vsd_state_e;

    typedef enum logic [1:0]
    {
        VSD_SRC_NONE     = 2'h0,
        VSD_SRC_SEPARATE = 2'h1,
        VSD_SRC_CS_HS    = 2'h2,
        VSD_SRC_CS_GREEN = 2'h3
    } vsd_src_e;
endpackage : vsd_pkg

// *** rtl/vsd_classify.sv ***
// Sync source decision from the activity bits
`timescale 1ns/100ps
`default_nettype none
module vsd_classify
(
    input  wire logic          hs_act,
    input  wire logic          vs_act,
    input  wire logic          green_act,
    input  wire logic          tri_seen,
    output vsd_pkg::vsd_src_e  source,
    output logic               tri_likely,
    output logic               mode_check
);
    always_comb
    begin
        source     = vsd_pkg::VSD_SRC_NONE;
        tri_likely = 1'b0;
        mode_check = 1'b0;
        if (hs_act && vs_act)
        begin
            source = vsd_pkg::VSD_SRC_SEPARATE;
        end
        else if (hs_act)
        begin
            source = vsd_pkg::VSD_SRC_CS_HS;
        end
        else if (!vs_act && green_act)
        begin
            source     = vsd_pkg::VSD_SRC_CS_GREEN;
            tri_likely = tri_seen;
            mode_check = !tri_seen;
        end
        else
        begin
            source = vsd_pkg::VSD_SRC_NONE;
        end
    end
endmodule // vsd_classify
`default_nettype wire

// *** rtl/vsd_tri_vote.sv ***
// Counts repeated status reads and notes whether any of them showed the trilevel bit
`timescale 1ns/100ps
`default_nettype none
module vsd_tri_vote
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        clear,
    input  wire logic        sample,
    input  wire logic        tri_bit,
    output logic [2:0]       polls,
    output logic             seen
);
    always_ff @(posedge clock)
    begin
        if (!reset_n || clear)
        begin
            polls <= 3'h0;
            seen  <= 1'b0;
        end
        else if (sample)
        begin
            polls <= polls + 3'h1;
            seen  <= seen | tri_bit;
        end
    end
endmodule // vsd_tri_vote
`default_nettype wire

// *** rtl/vsd_ctl.sv ***
// Host controller that programs a video digitizer and identifies its sync source
//
// Overview of operation
// - Host programs slicer code 001b for rising, 110b for falling edge lock.
// - Host loads 0x16 into the green sync slicer register as default.
// - Host always keeps the green sync low-pass filter bit set.
// - Host checks decision entries in order, first match wins.
// - Horizontal and vertical activity both set means separate sync.
// - Horizontal only: select composite on horizontal, then check composite detect.
// - Green only, no trilevel: composite on green, consult mode table.
// - Green and trilevel set: composite on green, likely trilevel.
// - No horizontal, vertical or green activity: no valid sync.
// - Composite source is written to input config and detect bit confirmed.
// - Horizontal and vertical activity outrank green activity.
// - Trilevel bit is read several times before trusting it.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "vsd_defs.svh"
module vsd_ctl
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [3:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata,
    output logic      [7:0]  dev_addr,
    output logic      [7:0]  dev_wdata,
    output logic             dev_wr,
    output logic             dev_rd,
    input  wire logic [7:0]  dev_rdata
);
    vsd_pkg::vsd_state_e state;
    vsd_pkg::vsd_state_e next_state;
    vsd_pkg::vsd_src_e   source;
    vsd_pkg::vsd_src_e   result_src;

    logic [7:0]  ctrl;
    logic [7:0]  line_hi;
    logic [7:0]  line_lo;
    logic [7:0]  phase;
    logic [7:0]  red_ofs;
    logic [7:0]  green_ofs;
    logic [7:0]  blue_ofs;
    logic [5:0]  ofs_lsb;
    logic [7:0]  act_status;
    logic [7:0]  pol_status;
    logic [3:0]  cfg_idx;
    logic [7:0]  rd_target;
    logic        confirmed;
    logic        tri_result;
    logic        mode_result;
    logic        done;
    logic        vote_clear;
    logic        vote_sample;
    logic [2:0]  polls;
    logic        tri_seen;
    logic        tri_likely;
    logic        mode_check;
    logic [15:0] cfg_word;

    wire logic apply_req  = sw_wr && (sw_addr == `VSD_REG_CTRL) && sw_wdata[`VSD_CTRL_APPLY];
    wire logic detect_req = sw_wr && (sw_addr == `VSD_REG_CTRL) && sw_wdata[`VSD_CTRL_DETECT];
    wire logic busy       = (state != vsd_pkg::VSD_IDLE);

    // Address and data of one step of the setup sequence
    function automatic logic [15:0] cfg_entry(input logic [3:0] idx);
        logic [7:0] ofs_ext;
        ofs_ext = 8'h00;
        // extension bits only in manual offset mode
        if (ctrl[`VSD_CTRL_SERVO_OFF])
        begin
            ofs_ext = {ofs_lsb, 2'h0};
        end
        ofs_ext[0] = ctrl[`VSD_CTRL_RANGE];
        case (idx)
            // slicer default, filter bit forced on
            4'h0:    cfg_entry = {`VSD_DEV_GREEN_SLICER, `VSD_GREEN_SLICER_DEF | `VSD_GREEN_LPF_MASK};
            4'h1:    cfg_entry = {`VSD_DEV_HS_SLICER, 5'h00,
                                  ctrl[`VSD_CTRL_FALL] ? `VSD_HS_THR_FALL : `VSD_HS_THR_RISE};
            // offsets, meaning set by the servo bit
            4'h2:    cfg_entry = {`VSD_DEV_RED_OFS, red_ofs};
            4'h3:    cfg_entry = {`VSD_DEV_GREEN_OFS, green_ofs};
            4'h4:    cfg_entry = {`VSD_DEV_BLUE_OFS, blue_ofs};
            4'h5:    cfg_entry = {`VSD_DEV_OFS_LSB_RANGE, ofs_ext};
            // line total drives the pixel clock
            4'h6:    cfg_entry = {`VSD_DEV_LINE_HI, line_hi};
            4'h7:    cfg_entry = {`VSD_DEV_LINE_LO, line_lo};
            4'h8:    cfg_entry = {`VSD_DEV_PHASE, phase & `VSD_PHASE_MASK};
            4'h9:    cfg_entry = {`VSD_DEV_SERVO_CTL, 7'h00, ctrl[`VSD_CTRL_SERVO_OFF]};
            default: cfg_entry = 16'h0000;
        endcase
    endfunction

    // Procedural so the word follows the settings that the function reads
    always_comb
    begin
        cfg_word = cfg_entry(cfg_idx);
    end

    vsd_classify u_classify
    (
        .hs_act     (act_status[`VSD_ST_HS]),
        .vs_act     (act_status[`VSD_ST_VS]),
        .green_act  (act_status[`VSD_ST_GREEN]),
        .tri_seen   (tri_seen),
        .source     (source),
        .tri_likely (tri_likely),
        .mode_check (mode_check)
    );

    vsd_tri_vote u_tri_vote
    (
        .clock   (clock),
        .reset_n (reset_n),
        .clear   (vote_clear),
        .sample  (vote_sample),
        .tri_bit (dev_rdata[`VSD_ST_TRI]),
        .polls   (polls),
        .seen    (tri_seen)
    );

    // True while the status read is the composite confirmation
    function automatic logic busy_confirm();
        busy_confirm = (result_src == vsd_pkg::VSD_SRC_CS_HS)
                    || (result_src == vsd_pkg::VSD_SRC_CS_GREEN);
    endfunction

    // Apply wins over a detect request in the same write
    assign vote_clear  = (state == vsd_pkg::VSD_IDLE) && detect_req && !apply_req;

    always_comb
    begin
        vote_sample = (state == vsd_pkg::VSD_CAP) && (rd_target == `VSD_DEV_SYNC_ACT)
                      && (polls != `VSD_TRI_POLLS) && !busy_confirm();
    end

    always_comb
    begin
        next_state = state;
        case (state)
            vsd_pkg::VSD_IDLE:
            begin
                if (apply_req)
                    next_state = vsd_pkg::VSD_CFG;
                else if (detect_req)
                    next_state = vsd_pkg::VSD_RD;
            end
            vsd_pkg::VSD_CFG:
            begin
                if (cfg_idx == `VSD_CFG_LAST)
                    next_state = vsd_pkg::VSD_IDLE;
            end
            vsd_pkg::VSD_RD:  next_state = vsd_pkg::VSD_GAP;
            vsd_pkg::VSD_GAP: next_state = vsd_pkg::VSD_CAP;
            vsd_pkg::VSD_CAP:
            begin
                if (rd_target == `VSD_DEV_SYNC_POL)
                    next_state = (source == vsd_pkg::VSD_SRC_NONE) ? vsd_pkg::VSD_IDLE
                                                                   : vsd_pkg::VSD_SEL;
                else if (busy_confirm())
                    next_state = vsd_pkg::VSD_IDLE;
                else
                    next_state = vsd_pkg::VSD_RD;
            end
            vsd_pkg::VSD_SEL:
            begin
                next_state = (source == vsd_pkg::VSD_SRC_SEPARATE) ? vsd_pkg::VSD_IDLE
                                                                   : vsd_pkg::VSD_RD;
            end
            default: next_state = vsd_pkg::VSD_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            state <= vsd_pkg::VSD_IDLE;
        else
            state <= next_state;
    end

    // Setup sequence index
    always_ff @(posedge clock)
    begin
        if (!reset_n || state != vsd_pkg::VSD_CFG)
            cfg_idx <= 4'h0;
        else
            cfg_idx <= cfg_idx + 4'h1;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            rd_target <= `VSD_DEV_SYNC_ACT;
        else if (state == vsd_pkg::VSD_IDLE)
            rd_target <= `VSD_DEV_SYNC_ACT;
        else if (state == vsd_pkg::VSD_CAP && rd_target == `VSD_DEV_SYNC_ACT
                 && !busy_confirm() && polls == `VSD_TRI_POLLS - 3'h1)
            rd_target <= `VSD_DEV_SYNC_POL;
        else if (state == vsd_pkg::VSD_SEL)
            rd_target <= `VSD_DEV_SYNC_ACT;
    end

    // Device register port
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            dev_addr  <= 8'h00;
            dev_wdata <= 8'h00;
            dev_wr    <= 1'b0;
            dev_rd    <= 1'b0;
        end
        else
        begin
            dev_wr <= 1'b0;
            dev_rd <= 1'b0;
            case (state)
                vsd_pkg::VSD_CFG:
                begin
                    dev_addr  <= cfg_word[15:8];
                    dev_wdata <= cfg_word[7:0];
                    dev_wr    <= 1'b1;
                end
                vsd_pkg::VSD_RD:
                begin
                    dev_addr <= rd_target;
                    dev_rd   <= 1'b1;
                end
                vsd_pkg::VSD_SEL:
                begin
                    dev_addr <= `VSD_DEV_INPUT_CFG;
                    dev_wr   <= 1'b1;
                    case (source)
                        vsd_pkg::VSD_SRC_CS_HS:    dev_wdata <= {3'h0, `VSD_SEL_COMPOSITE_SYNC_HS, 3'h0};
                        vsd_pkg::VSD_SRC_CS_GREEN: dev_wdata <= {3'h0, `VSD_SEL_COMPOSITE_SYNC_GREEN, 3'h0};
                        default:                   dev_wdata <= {3'h0, `VSD_SEL_SEPARATE, 3'h0};
                    endcase
                end
                default:
                begin
                    dev_addr  <= dev_addr;
                    dev_wdata <= dev_wdata;
                end
            endcase
        end
    end

    // Captured device status and decision outcome
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            act_status  <= 8'h00;
            pol_status  <= 8'h00;
            result_src  <= vsd_pkg::VSD_SRC_NONE;
            confirmed   <= 1'b0;
            tri_result  <= 1'b0;
            mode_result <= 1'b0;
            done        <= 1'b0;
        end
        else if (state == vsd_pkg::VSD_IDLE && detect_req && !apply_req)
        begin
            result_src <= vsd_pkg::VSD_SRC_NONE;
            confirmed  <= 1'b0;
            done       <= 1'b0;
        end
        else if (state == vsd_pkg::VSD_CAP)
        begin
            if (rd_target == `VSD_DEV_SYNC_POL)
            begin
                pol_status  <= dev_rdata;
                result_src  <= source;
                tri_result  <= tri_likely;
                mode_result <= mode_check;
                done        <= (source == vsd_pkg::VSD_SRC_NONE);
            end
            else if (busy_confirm())
            begin
                // composite must show its detect bit
                confirmed <= dev_rdata[`VSD_ST_COMPOSITE_SYNC];
                done      <= 1'b1;
            end
            else
            begin
                act_status <= dev_rdata;
            end
        end
        else if (state == vsd_pkg::VSD_SEL && source == vsd_pkg::VSD_SRC_SEPARATE)
        begin
            done <= 1'b1;
        end
    end

    // Software writable settings
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            ctrl      <= 8'h00;
            line_hi   <= 8'h00;
            line_lo   <= 8'h00;
            phase     <= 8'h00;
            red_ofs   <= 8'h00;
            green_ofs <= 8'h00;
            blue_ofs  <= 8'h00;
            ofs_lsb   <= 6'h00;
        end
        else if (sw_wr && !busy)
        begin
            case (sw_addr)
                `VSD_REG_CTRL:      ctrl      <= {3'h0, sw_wdata[4:2], 2'h0};
                `VSD_REG_LINE_HI:   line_hi   <= sw_wdata;
                `VSD_REG_LINE_LO:   line_lo   <= sw_wdata;
                `VSD_REG_PHASE:     phase     <= sw_wdata & `VSD_PHASE_MASK;
                `VSD_REG_RED_OFS:   red_ofs   <= sw_wdata;
                `VSD_REG_GREEN_OFS: green_ofs <= sw_wdata;
                `VSD_REG_BLUE_OFS:  blue_ofs  <= sw_wdata;
                `VSD_REG_OFS_LSB:   ofs_lsb   <= sw_wdata[5:0];
                default:            ctrl      <= ctrl;
            endcase
        end
    end

    // Software read port, data one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            sw_rdata <= 8'h00;
        else if (sw_rd)
        begin
            case (sw_addr)
                `VSD_REG_CTRL:      sw_rdata <= {busy, ctrl[6:0]};
                `VSD_REG_LINE_HI:   sw_rdata <= line_hi;
                `VSD_REG_LINE_LO:   sw_rdata <= line_lo;
                `VSD_REG_PHASE:     sw_rdata <= phase;
                `VSD_REG_RED_OFS:   sw_rdata <= red_ofs;
                `VSD_REG_GREEN_OFS: sw_rdata <= green_ofs;
                `VSD_REG_BLUE_OFS:  sw_rdata <= blue_ofs;
                `VSD_REG_OFS_LSB:   sw_rdata <= {2'h0, ofs_lsb};
                `VSD_REG_RESULT:    sw_rdata <= {done, 1'b0, mode_result, tri_result,
                                                 confirmed, 1'b0, result_src};
                `VSD_REG_ACT:       sw_rdata <= act_status;
                `VSD_REG_POL:       sw_rdata <= pol_status;
                default:            sw_rdata <= 8'h00;
            endcase
        end
        else
            sw_rdata <= 8'h00;
    end

    sequence s_green_wr;
        dev_wr && dev_addr == `VSD_DEV_GREEN_SLICER;
    endsequence

    sequence s_comp_sel;
        dev_wr && dev_addr == `VSD_DEV_INPUT_CFG && dev_wdata[4:3] != `VSD_SEL_SEPARATE;
    endsequence

    sequence s_status_rd;
        dev_rd && dev_addr == `VSD_DEV_SYNC_ACT;
    endsequence

    a_green_default: assert property (@(posedge clock) disable iff (!reset_n)
        s_green_wr |-> dev_wdata == `VSD_GREEN_SLICER_DEF)
        else $error("green slicer default not loaded");

    a_green_lpf_on: assert property (@(posedge clock) disable iff (!reset_n)
        s_green_wr |-> (dev_wdata & `VSD_GREEN_LPF_MASK) != 8'h00)
        else $error("green low-pass filter left off");

    a_hs_thresh_edge: assert property (@(posedge clock) disable iff (!reset_n)
        dev_wr && dev_addr == `VSD_DEV_HS_SLICER |->
        dev_wdata[2:0] == (ctrl[`VSD_CTRL_FALL] ? `VSD_HS_THR_FALL : `VSD_HS_THR_RISE))
        else $error("slicer threshold does not match edge");

    a_comp_confirm: assert property (@(posedge clock) disable iff (!reset_n)
        s_comp_sel |-> ##1 s_status_rd ##2 done && confirmed == $past(dev_rdata[`VSD_ST_COMPOSITE_SYNC]))
        else $error("composite select not confirmed");

    a_sep_first: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(done) && act_status[`VSD_ST_HS] && act_status[`VSD_ST_VS]
        |-> result_src == vsd_pkg::VSD_SRC_SEPARATE)
        else $error("separate sync not chosen first");

    a_hs_only_comp: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(done) && act_status[`VSD_ST_HS] && !act_status[`VSD_ST_VS]
        |-> result_src == vsd_pkg::VSD_SRC_CS_HS)
        else $error("horizontal composite not chosen");

    a_no_sync: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(done) && act_status[2:0] == 3'h0 |-> result_src == vsd_pkg::VSD_SRC_NONE)
        else $error("missing sync not reported");

    a_green_tri: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(done) && result_src == vsd_pkg::VSD_SRC_CS_GREEN |-> tri_result != mode_result)
        else $error("green composite trilevel flags wrong");

    a_tri_polls: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(done) && result_src != vsd_pkg::VSD_SRC_NONE |-> polls == `VSD_TRI_POLLS)
        else $error("trilevel not polled enough");
endmodule // vsd_ctl
`default_nettype wire

// *** tb/vsd_dev_model.sv ***
// Behavioural digitizer register model on the controller's device port
`timescale 1ns/100ps
`default_nettype none
module vsd_dev_model
(
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic [7:0] dev_addr,
    input  wire logic [7:0] dev_wdata,
    input  wire logic       dev_wr,
    input  wire logic       dev_rd,
    output logic      [7:0] dev_rdata,
    input  wire logic [3:0] act_in,
    input  wire logic       cs_ok,
    input  wire logic [7:0] pol_in
);
    logic [7:0] regs [0:31];
    logic       cs_present;

    assign cs_present = cs_ok && (regs[5][4:3] != 2'h0);

    // per-channel offsets, loop and phase settings held
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 32; i++)
                regs[i] <= 8'h00;
        end
        else if (dev_wr)
            regs[dev_addr[4:0]] <= dev_wdata;
    end

    // status and polarity, activity as seen after the glitch filter
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            dev_rdata <= 8'h00;
        else if (!dev_rd)
            dev_rdata <= ~dev_rdata;
        else if (dev_addr == 8'h01)
            dev_rdata <= {3'h0, cs_present, act_in};
        else if (dev_addr == 8'h02)
            dev_rdata <= pol_in;
        else
            dev_rdata <= regs[dev_addr[4:0]];
    end
endmodule // vsd_dev_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the sync detect controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic       clock;
    logic       reset_n = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic       sw_wr = 1'b0;
    logic       sw_rd = 1'b0;
    logic [7:0] sw_rdata;
    logic [7:0] dev_addr;
    logic [7:0] dev_wdata;
    logic       dev_wr;
    logic       dev_rd;
    logic [7:0] dev_rdata;
    logic [3:0] act_in = 4'h0;
    logic       cs_ok = 1'b0;
    logic [7:0] rd;
    int         num_errors = 0;
    int         checks = 0;
    int         cycles = 0;
    logic [4:0] st [7] = '{5'h13, 5'h17, 5'h11, 5'h01, 5'h14, 5'h1c, 5'h18};
    logic [7:0] ex [7] = '{8'h81, 8'h81, 8'h8a, 8'h82, 8'hab, 8'h9b, 8'h80};
    logic [1:0] se [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};

    vsd_ctl dut (.clock(clock), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    vsd_dev_model dev (.clock(clock), .reset_n(reset_n), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
        .act_in(act_in), .cs_ok(cs_ok), .pol_in(8'h2a));

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            conclude();
        end
    end

    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clock);
        sw_wr <= 1'b0;
    endtask

    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clock);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    // Polls the busy flag under a bound
    task automatic wait_idle();
        int n;
        n = 0;
        rd = 8'h80;
        while (rd[7] === 1'b1 && n < 200)
        begin
            sw_read(4'h0, rd);
            n++;
        end
        `CHK("idle", 1'b0, rd[7])
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        sw_read(4'h8, rd);
        `CHK("result after reset", 8'h00, rd)
        `CHK("dev_wr after reset", 1'b0, dev_wr)
        sw_read(4'hf, rd);
        `CHK("unmapped read", 8'h00, rd)
        $display("test reset done");
        for (int k = 0; k < 2; k++)
        begin
            sw_write(4'h1, 8'h03);
            sw_write(4'h2, 8'h20);
            sw_write(4'h3, 8'hff);
            sw_write(4'h4, 8'h11);
            sw_write(4'h5, 8'h22);
            sw_write(4'h6, 8'h33);
            sw_write(4'h7, 8'h2d);
            sw_write(4'h0, k ? 8'h05 : 8'h19);
            sw_write(4'h1, 8'hee);
            wait_idle();
            sw_read(4'h1, rd);
            `CHK("write while busy", 8'h03, rd)
            `CHK("hs slicer", k ? 3'h6 : 3'h1, dev.regs[3][2:0])
            `CHK("green slicer", 8'h16, dev.regs[4])
            `CHK("red offset", 8'h11, dev.regs[9])
            `CHK("green offset", 8'h22, dev.regs[10])
            `CHK("blue offset", 8'h33, dev.regs[11])
            `CHK("offset lsbs", k ? 8'h00 : 8'hb5, dev.regs[12])
            `CHK("line high", 8'h03, dev.regs[14])
            `CHK("line low", 8'h20, dev.regs[15])
            `CHK("phase", 8'h3f, dev.regs[16])
            `CHK("servo ctl", k ? 8'h00 : 8'h01, dev.regs[23])
            $display("test apply %0d done", k);
        end
        for (int i = 0; i < 7; i++)
        begin
            act_in <= st[i][3:0];
            cs_ok <= st[i][4];
            sw_write(4'h0, 8'h02);
            wait_idle();
            sw_read(4'h8, rd);
            `CHK("result", ex[i], rd)
            if (i < 6)
                `CHK("source select", se[i], dev.regs[5][4:3])
            sw_read(4'h9, rd);
            `CHK("activity", st[i][3:0], rd[3:0])
            sw_read(4'ha, rd);
            `CHK("polarity", 8'h2a, rd)
            $display("test detect %0d done", i);
        end
        sw_write(4'h0, 8'h03);
        wait_idle();
        sw_read(4'h8, rd);
        `CHK("result kept", 8'h80, rd)
        `CHK("hs slicer after apply", 3'h1, dev.regs[3][2:0])
        $display("test apply over detect done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
